/* logic/fofu_unit.sv */
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
// What this block does
// - Accepts and produces 16-bit and 32-bit two's complement integers.
// - Integer most significant bit is the sign, both widths.
// - Single float is 32 bits, double float 64 bits in memory.
// - Float layout: sign on top, 8 exponent bits, 23 or 55 fraction.
// - Sign-magnitude fraction; negation flips only the sign bit.
// - Normalize so internal bit 59 is zero and bit 58 is one.
// - Overflow bit 59 set: shift fraction right once, exponent plus one.
// - Hidden bit 58 dropped on store, reinserted on load.
// - Double keeps guard bits below fraction for rounding and shifts.
// - Exponent stored as true exponent plus 200 octal.
// - Codes 0..377 octal mean -200..+177; exponent code 0 means zero.
// - Biased exponent below 0 flags underflow, above 377 octal overflow.
// - Word0 sign/exponent/upper fraction; later words fill lower fraction bits.
// - Keeps carry, overflow, zero, negative codes for the host flags.
// - Status holds busy, condition codes, underflow and overflow flags; control holds three mode bits and the underflow enable.
// - Precision select set means double, clear means single.
// - Long integer select picks 32-bit integers, else 16-bit.
// - Truncate select truncates float store results; clear rounds them.
// - Underflow with underflow enable clear forces a zero result.
module fofu_unit
    import fofu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic float_carry_code,
    output logic float_overflow_code,
    output logic float_zero_code,
    output logic float_negative_code,
    output logic busy
);
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [3:0] ctrl_q;
    fofu_state_e state_q;
    logic sign_q;
    logic signed [FOFU_EXP_W-1:0] exp_q;
    logic [FOFU_FRAC_W-1:0] frac_q;
    logic [15:0] word_q [4];
    logic cc_c_q;
    logic cc_v_q;
    logic cc_z_q;
    logic cc_n_q;
    logic unf_q;
    logic ovf_q;
    logic busy_q;
    logic wr_fire;
    logic mapped;
    logic [31:0] rd_val;
    logic double_precision_select;
    logic long_integer_select;
    logic truncate_select;
    logic underflow_interrupt_enable;
    logic [FOFU_FRAC_W-1:0] unpack_frac;
    logic [7:0] unpack_exp;
    logic [31:0] int_in;
    logic [31:0] int_mag;
    logic [FOFU_FRAC_W-1:0] rnd_unit;
    logic [FOFU_FRAC_W-1:0] keep_mask;
    logic signed [FOFU_EXP_W-1:0] exp_true;
    logic [5:0] int_shift;
    logic [31:0] fi_mag;
    logic [31:0] fi_lim;
    logic fi_err;
    logic [31:0] fi_res;

    assign double_precision_select = ctrl_q[FOFU_CTRL_DP_BIT];
    assign long_integer_select = ctrl_q[FOFU_CTRL_LI_BIT];
    assign truncate_select = ctrl_q[FOFU_CTRL_TR_BIT];
    assign underflow_interrupt_enable = ctrl_q[FOFU_CTRL_UIE_BIT];
    assign wr_fire = psel && penable && pready_q && pwrite;

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign float_carry_code = cc_c_q;
    assign float_overflow_code = cc_v_q;
    assign float_zero_code = cc_z_q;
    assign float_negative_code = cc_n_q;
    assign busy = busy_q;

    // Address decode and read mux
    always_comb begin
        mapped = 1'b1;
        rd_val = FOFU_RD_DEAD;
        case (paddr)
            FOFU_CTRL_OFS: rd_val = {28'h0000000, ctrl_q};
            FOFU_CMD_OFS: rd_val = FOFU_RD_DEAD;
            FOFU_STAT_OFS: begin
                rd_val[FOFU_ST_BUSY_BIT] = (state_q != FOFU_IDLE);
                rd_val[FOFU_ST_C_BIT] = cc_c_q;
                rd_val[FOFU_ST_V_BIT] = cc_v_q;
                rd_val[FOFU_ST_Z_BIT] = cc_z_q;
                rd_val[FOFU_ST_N_BIT] = cc_n_q;
                rd_val[FOFU_ST_UNF_BIT] = unf_q;
                rd_val[FOFU_ST_OVF_BIT] = ovf_q;
            end
            FOFU_WORD0_OFS: rd_val = {16'h0000, word_q[0]};
            FOFU_WORD1_OFS: rd_val = {16'h0000, word_q[1]};
            FOFU_WORD2_OFS: rd_val = {16'h0000, word_q[2]};
            FOFU_WORD3_OFS: rd_val = {16'h0000, word_q[3]};
            FOFU_EXP_OFS: rd_val = {{21{exp_q[FOFU_EXP_W-1]}}, exp_q};
            FOFU_FRHI_OFS: rd_val = {sign_q, 3'h0, frac_q[59:32]};
            FOFU_FRLO_OFS: rd_val = frac_q[31:0];
            default: mapped = 1'b0;
        endcase
    end

    // APB slave: one wait state, then answer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= FOFU_RD_DEAD;
        end else if (psel && penable && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= !mapped;
            prdata_q <= pwrite ? FOFU_RD_DEAD : rd_val;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= FOFU_CTRL_RST;
        end else if (wr_fire && paddr == FOFU_CTRL_OFS) begin
            ctrl_q <= pwdata[3:0];
        end
    end

    // Registered copy of the non-idle state so the pin cannot glitch
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else if (state_q == FOFU_IDLE) begin
            busy_q <= wr_fire && paddr == FOFU_CMD_OFS && (pwdata[2:0] == FOFU_CMD_LOAD_FLT
                || pwdata[2:0] == FOFU_CMD_LOAD_INT || pwdata[2:0] == FOFU_CMD_STORE_FLT);
        end else if (state_q == FOFU_PACK || (state_q == FOFU_NORM && frac_q == '0)) begin
            busy_q <= 1'b0;
        end
    end

    // Memory words to internal word; software supplies normalized operands
    always_comb begin
        unpack_exp = word_q[0][14:7];
        unpack_frac = '0;
        unpack_frac[FOFU_HID_BIT] = 1'b1;
        unpack_frac[FOFU_W0_HI -: 7] = word_q[0][6:0];
        unpack_frac[FOFU_W1_HI -: 16] = word_q[1];
        if (double_precision_select) begin
            unpack_frac[FOFU_W2_HI -: 16] = word_q[2];
            unpack_frac[FOFU_W3_HI -: 16] = word_q[3];
        end
        // Short integers sit in word 0 and are sign-extended
        if (long_integer_select) begin
            int_in = {word_q[0], word_q[1]};
        end else begin
            int_in = {{16{word_q[0][15]}}, word_q[0]};
        end
        int_mag = int_in[31] ? (32'h00000000 - int_in) : int_in;
    end

    // Rounding position: guard bits hold the round bit in double
    always_comb begin
        if (double_precision_select) begin
            rnd_unit = 60'h1 << FOFU_DP_RND_BIT;
        end else begin
            rnd_unit = 60'h1 << FOFU_SP_RND_BIT;
        end
        keep_mask = ~((rnd_unit << 1) - 60'h1);
    end

    // Float to integer: fraction shifted by true exponent
    always_comb begin
        exp_true = exp_q - FOFU_EXP_BIAS;
        fi_lim = long_integer_select ? FOFU_I32_MAXP : FOFU_I16_MAXP;
        int_shift = 6'(FOFU_EXP_INT32 - exp_true);
        fi_mag = 32'h00000000;
        fi_err = 1'b0;
        if (frac_q != '0 && exp_true > FOFU_EXP_ZERO) begin
            if (exp_true > (long_integer_select ? FOFU_EXP_INT32 : FOFU_EXP_INT16)) begin
                fi_err = 1'b1;
            end else begin
                fi_mag = frac_q[FOFU_HID_BIT:FOFU_INT_LO] >> int_shift;
                fi_err = (fi_mag > fi_lim) && !(sign_q && fi_mag == fi_lim + 32'h1);
            end
        end
        // Destination cleared on a conversion error
        if (fi_err) begin
            fi_res = 32'h00000000;
        end else begin
            fi_res = sign_q ? (32'h00000000 - fi_mag) : fi_mag;
        end
    end

    // Operation sequencer and internal accumulator
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= FOFU_IDLE;
            sign_q <= 1'b0;
            exp_q <= FOFU_EXP_ZERO;
            frac_q <= '0;
            for (int i = 0; i < 4; i++) begin
                word_q[i] <= 16'h0000;
            end
            cc_c_q <= 1'b0;
            cc_v_q <= 1'b0;
            cc_z_q <= 1'b1;
            cc_n_q <= 1'b0;
            unf_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            case (state_q)
                FOFU_IDLE: begin
                    if (wr_fire && paddr == FOFU_WORD0_OFS) begin
                        word_q[0] <= pwdata[15:0];
                    end
                    if (wr_fire && paddr == FOFU_WORD1_OFS) begin
                        word_q[1] <= pwdata[15:0];
                    end
                    if (wr_fire && paddr == FOFU_WORD2_OFS) begin
                        word_q[2] <= pwdata[15:0];
                    end
                    if (wr_fire && paddr == FOFU_WORD3_OFS) begin
                        word_q[3] <= pwdata[15:0];
                    end
                    if (wr_fire && paddr == FOFU_CMD_OFS) begin
                        unf_q <= 1'b0;
                        ovf_q <= 1'b0;
                        cc_c_q <= 1'b0;
                        case (pwdata[2:0])
                            FOFU_CMD_LOAD_FLT: begin
                                sign_q <= word_q[0][15];
                                // Exponent code 0 is taken as zero
                                if (unpack_exp == 8'h00) begin
                                    exp_q <= FOFU_EXP_ZERO;
                                    frac_q <= '0;
                                end else begin
                                    exp_q <= FOFU_EXP_W'(unpack_exp);
                                    frac_q <= unpack_frac;
                                end
                                state_q <= FOFU_NORM;
                            end
                            FOFU_CMD_LOAD_INT: begin
                                sign_q <= int_in[31];
                                exp_q <= FOFU_EXP_BIAS + FOFU_EXP_INT32;
                                frac_q <= {1'b0, int_mag, 27'h0000000};
                                state_q <= FOFU_NORM;
                            end
                            FOFU_CMD_STORE_FLT: state_q <= FOFU_ROUND;
                            FOFU_CMD_STORE_INT: begin
                                cc_c_q <= fi_err;
                                cc_v_q <= 1'b0;
                                cc_z_q <= (fi_res == 32'h00000000);
                                cc_n_q <= fi_res[31];
                                if (long_integer_select) begin
                                    word_q[0] <= fi_res[31:16];
                                    word_q[1] <= fi_res[15:0];
                                end else begin
                                    word_q[0] <= fi_res[15:0];
                                end
                            end
                            FOFU_CMD_NEGATE: begin
                                sign_q <= !sign_q;
                                cc_n_q <= !sign_q && frac_q != '0;
                            end
                            default: ;
                        endcase
                    end
                end
                FOFU_NORM: begin
                    if (frac_q == '0) begin
                        sign_q <= 1'b0;
                        exp_q <= FOFU_EXP_ZERO;
                        cc_z_q <= 1'b1;
                        cc_n_q <= 1'b0;
                        cc_v_q <= 1'b0;
                        state_q <= FOFU_IDLE;
                    end else if (frac_q[FOFU_OVF_BIT]) begin
                        frac_q <= frac_q >> 1;
                        exp_q <= exp_q + 11'sh001;
                    end else if (!frac_q[FOFU_HID_BIT]) begin
                        // One place per cycle keeps the shifter small
                        frac_q <= frac_q << 1;
                        exp_q <= exp_q - 11'sh001;
                    end else begin
                        state_q <= FOFU_FIX;
                    end
                end
                FOFU_ROUND: begin
                    if (truncate_select) begin
                        frac_q <= frac_q & keep_mask;
                    end else begin
                        frac_q <= (frac_q + rnd_unit) & keep_mask;
                    end
                    state_q <= FOFU_FIX;
                end
                FOFU_FIX: begin
                    if (frac_q[FOFU_OVF_BIT]) begin
                        frac_q <= frac_q >> 1;
                        exp_q <= exp_q + 11'sh001;
                    end else if (exp_q < FOFU_EXP_ZERO) begin
                        unf_q <= 1'b1;
                        cc_v_q <= 1'b0;
                        if (!underflow_interrupt_enable) begin
                            sign_q <= 1'b0;
                            exp_q <= FOFU_EXP_ZERO;
                            frac_q <= '0;
                        end
                        state_q <= FOFU_PACK;
                    end else begin
                        ovf_q <= (exp_q > FOFU_EXP_MAX);
                        cc_v_q <= (exp_q > FOFU_EXP_MAX);
                        state_q <= FOFU_PACK;
                    end
                end
                FOFU_PACK: begin
                    // Exponent field wraps by 400 octal when out of range
                    cc_z_q <= (exp_q[7:0] == 8'h00) || frac_q == '0;
                    cc_n_q <= sign_q && exp_q[7:0] != 8'h00 && frac_q != '0;
                    if (exp_q[7:0] == 8'h00 || frac_q == '0) begin
                        for (int i = 0; i < 4; i++) begin
                            word_q[i] <= 16'h0000;
                        end
                    end else begin
                        word_q[0] <= {sign_q, exp_q[7:0], frac_q[FOFU_W0_HI -: 7]};
                        word_q[1] <= frac_q[FOFU_W1_HI -: 16];
                        if (double_precision_select) begin
                            word_q[2] <= frac_q[FOFU_W2_HI -: 16];
                            word_q[3] <= frac_q[FOFU_W3_HI -: 16];
                        end
                    end
                    state_q <= FOFU_IDLE;
                end
                default: state_q <= FOFU_IDLE;
            endcase
        end
    end
endmodule

/* shared/fofu_pkg.sv */
package fofu_pkg;
    // Register byte offsets
    localparam logic [7:0] FOFU_CTRL_OFS = 8'h00;
    localparam logic [7:0] FOFU_CMD_OFS = 8'h04;
    localparam logic [7:0] FOFU_STAT_OFS = 8'h08;
    localparam logic [7:0] FOFU_WORD0_OFS = 8'h0C;
    localparam logic [7:0] FOFU_WORD1_OFS = 8'h10;
    localparam logic [7:0] FOFU_WORD2_OFS = 8'h14;
    localparam logic [7:0] FOFU_WORD3_OFS = 8'h18;
    localparam logic [7:0] FOFU_EXP_OFS = 8'h1C;
    localparam logic [7:0] FOFU_FRHI_OFS = 8'h20;
    localparam logic [7:0] FOFU_FRLO_OFS = 8'h24;
    // Control register fields
    localparam int FOFU_CTRL_DP_BIT = 0;
    localparam int FOFU_CTRL_LI_BIT = 1;
    localparam int FOFU_CTRL_TR_BIT = 2;
    localparam int FOFU_CTRL_UIE_BIT = 3;
    localparam logic [3:0] FOFU_CTRL_RST = 4'h0;
    // Status register fields
    localparam int FOFU_ST_BUSY_BIT = 0;
    localparam int FOFU_ST_C_BIT = 1;
    localparam int FOFU_ST_V_BIT = 2;
    localparam int FOFU_ST_Z_BIT = 3;
    localparam int FOFU_ST_N_BIT = 4;
    localparam int FOFU_ST_UNF_BIT = 5;
    localparam int FOFU_ST_OVF_BIT = 6;
    // Commands
    localparam logic [2:0] FOFU_CMD_LOAD_FLT = 3'h1;
    localparam logic [2:0] FOFU_CMD_LOAD_INT = 3'h2;
    localparam logic [2:0] FOFU_CMD_STORE_FLT = 3'h3;
    localparam logic [2:0] FOFU_CMD_STORE_INT = 3'h4;
    localparam logic [2:0] FOFU_CMD_NEGATE = 3'h5;
    // Internal word layout
    localparam int FOFU_FRAC_W = 60;
    localparam int FOFU_OVF_BIT = 59;
    localparam int FOFU_HID_BIT = 58;
    localparam int FOFU_W0_HI = 57;
    localparam int FOFU_W1_HI = 50;
    localparam int FOFU_W2_HI = 34;
    localparam int FOFU_W3_HI = 18;
    localparam int FOFU_SP_RND_BIT = 34;
    localparam int FOFU_DP_RND_BIT = 2;
    localparam int FOFU_INT_LO = 27;
    // Exponent, excess 200 octal
    localparam int FOFU_EXP_W = 11;
    localparam logic signed [10:0] FOFU_EXP_BIAS = 11'sh080;
    localparam logic signed [10:0] FOFU_EXP_MAX = 11'sh0FF;
    localparam logic signed [10:0] FOFU_EXP_ZERO = 11'sh000;
    localparam logic signed [10:0] FOFU_EXP_INT32 = 11'sh020;
    localparam logic signed [10:0] FOFU_EXP_INT16 = 11'sh010;
    localparam logic [31:0] FOFU_I32_MAXP = 32'h7FFFFFFF;
    localparam logic [31:0] FOFU_I16_MAXP = 32'h00007FFF;
    localparam logic [31:0] FOFU_RD_DEAD = 32'h00000000;
    typedef enum logic [2:0] {
        FOFU_IDLE, FOFU_NORM, FOFU_ROUND, FOFU_FIX, FOFU_PACK
    } fofu_state_e;
endpackage

/* tb/fofu_unit_props.sv */
`timescale 1ns/1ps
module fofu_unit_props
    import fofu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic float_carry_code,
    input wire logic float_overflow_code,
    input wire logic float_zero_code,
    input wire logic float_negative_code,
    input wire logic busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic cmd_w;
    // Busy commands are dropped, so only idle ones count
    assign cmd_w = pready && psel && pwrite && paddr == FOFU_CMD_OFS && !busy;
    chk_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("ready not after one wait state");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_err_unmapped: assert property (
        pready && paddr > FOFU_FRLO_OFS |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_ok_mapped: assert property (
        pready && paddr <= FOFU_FRLO_OFS && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    chk_cmd_reads: assert property (
        pready && !pwrite && paddr == FOFU_CMD_OFS |-> prdata == 32'h0)
        else $error("command register read not zero");
    chk_neg_fast: assert property (
        cmd_w && pwdata[2:0] == FOFU_CMD_NEGATE |=> !busy [*2])
        else $error("negate went busy");
    chk_load_busy: assert property (
        cmd_w && pwdata[2:0] == FOFU_CMD_LOAD_FLT |=> busy)
        else $error("load did not start");
    chk_busy_bound: assert property ($rose(busy) |-> ##[1:80] !busy)
        else $error("operation too long");
    chk_codes_hold: assert property (!busy && !cmd_w |=> $stable({float_carry_code,
        float_overflow_code, float_zero_code, float_negative_code}))
        else $error("codes changed without command");
endmodule
bind fofu_unit fofu_unit_props fofu_unit_props_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .float_carry_code(float_carry_code), .float_overflow_code(float_overflow_code),
    .float_zero_code(float_zero_code), .float_negative_code(float_negative_code),
    .busy(busy));

/* tb/fofu_host.sv */
`timescale 1ns/1ps
module fofu_host (
    input wire logic clk_sys,
    output logic [7:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
    end
    // Held until ready; data inverted after release so nothing stale looks valid
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Waits for as long as it takes; only the bench timeout ends a hang
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import fofu_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cc_c;
    logic cc_v;
    logic cc_z;
    logic cc_n;
    logic busy;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    always #2.5 clk_sys = ~clk_sys;
    fofu_unit fofu_unit_inst (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .float_carry_code(cc_c),
        .float_overflow_code(cc_v), .float_zero_code(cc_z), .float_negative_code(cc_n),
        .busy(busy));
    fofu_host fofu_host_inst (.clk_sys(clk_sys), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    task automatic summarize();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        fofu_host_inst.xfer(1'b1, a, d, r, e);
    endtask
    task automatic rc(input logic [7:0] a, input string n, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        fofu_host_inst.xfer(1'b0, a, 32'h0, r, e);
        chk(n, x, r);
    endtask
    task automatic op(input logic [2:0] c);
        logic [31:0] s;
        logic e;
        wr(FOFU_CMD_OFS, {29'h0, c});
        do begin
            fofu_host_inst.xfer(1'b0, FOFU_STAT_OFS, 32'h0, s, e);
        end while (s[FOFU_ST_BUSY_BIT] !== 1'b0);
    endtask
    task automatic load(input logic [3:0] m, input logic [15:0] w0, input logic [15:0] w1,
        input logic [2:0] c);
        wr(FOFU_CTRL_OFS, {28'h0, m});
        wr(FOFU_WORD0_OFS, {16'h0, w0});
        wr(FOFU_WORD1_OFS, {16'h0, w1});
        op(c);
    endtask
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rc(FOFU_STAT_OFS, "status", 32'h00000008);
        rc(FOFU_CTRL_OFS, "control", 32'h0);
        fofu_host_inst.xfer(1'b0, 8'h40, 32'h0, r, e);
        chk("refused", 32'h1, {31'h0, e});
        wr(FOFU_CTRL_OFS, 32'h0000000F);
        rc(FOFU_CTRL_OFS, "mode bits", 32'h0000000F);
        $display("test reset done");
    endtask
    task automatic t_single();
        load(4'h0, 16'h4080, 16'h0, FOFU_CMD_LOAD_FLT);
        rc(FOFU_EXP_OFS, "exponent", 32'h81);
        rc(FOFU_FRHI_OFS, "hidden", 32'h04000000);
        op(FOFU_CMD_NEGATE);
        rc(FOFU_FRHI_OFS, "negated", 32'h84000000);
        chk("negative", 32'h1, {31'h0, cc_n});
        op(FOFU_CMD_STORE_FLT);
        rc(FOFU_WORD0_OFS, "stored hi", 32'hC080);
        rc(FOFU_WORD1_OFS, "stored lo", 32'h0);
        load(4'h0, 16'h0040, 16'h1234, FOFU_CMD_LOAD_FLT);
        chk("zero code", 32'h1, {31'h0, cc_z});
        $display("test single done");
    endtask
    task automatic t_double();
        wr(FOFU_WORD2_OFS, 32'h0);
        wr(FOFU_WORD3_OFS, 32'h1);
        load(4'h1, 16'h4080, 16'h0, FOFU_CMD_LOAD_FLT);
        rc(FOFU_FRLO_OFS, "low fraction", 32'h00000008);
        op(FOFU_CMD_STORE_FLT);
        rc(FOFU_WORD3_OFS, "last word", 32'h1);
        $display("test double done");
    endtask
    task automatic t_ints();
        logic [47:0] tab [3];
        tab[0] = {4'h0, 16'h0005, 16'h0000, 12'h083};
        tab[1] = {4'h0, 16'hFFFB, 16'h0000, 12'h083};
        tab[2] = {4'h2, 16'h0001, 16'h0000, 12'h091};
        for (int i = 0; i < 3; i++) begin
            load(tab[i][47:44], tab[i][43:28], tab[i][27:12], FOFU_CMD_LOAD_INT);
            rc(FOFU_EXP_OFS, "int exponent", {20'h0, tab[i][11:0]});
            rc(FOFU_FRHI_OFS, "int fraction", {i == 1, 6'h02, i != 2, 24'h0});
            chk("int sign", {31'h0, i == 1}, {31'h0, cc_n});
            op(FOFU_CMD_STORE_INT);
            rc(FOFU_WORD0_OFS, "int back", {16'h0, tab[i][43:28]});
        end
        load(4'h0, 16'h4880, 16'h0, FOFU_CMD_LOAD_FLT);
        op(FOFU_CMD_STORE_INT);
        chk("carry", 32'h1, {31'h0, cc_c});
        rc(FOFU_WORD0_OFS, "cleared", 32'h0);
        $display("test integers done");
    endtask
    task automatic t_round();
        for (int t = 0; t < 2; t++) begin
            load({1'b0, t[0], 2'h2}, 16'h0100, 16'h0001, FOFU_CMD_LOAD_INT);
            op(FOFU_CMD_STORE_FLT);
            rc(FOFU_WORD0_OFS, "rounded hi", 32'h4C80);
            rc(FOFU_WORD1_OFS, "rounded lo", {31'h0, t == 0});
        end
        // Rounding carries out of the fraction and renormalizes
        load(4'h2, 16'h01FF, 16'hFFFF, FOFU_CMD_LOAD_INT);
        op(FOFU_CMD_STORE_FLT);
        rc(FOFU_WORD0_OFS, "carry out", 32'h4D00);
        rc(FOFU_WORD1_OFS, "carry out lo", 32'h0);
        chk("overflow code", 32'h0, {31'h0, cc_v});
        chk("idle", 32'h0, {31'h0, busy});
        $display("test rounding done");
    endtask
    // Cuts a hang short; ceiling well above the whole run
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_single();
        t_double();
        t_ints();
        t_round();
        summarize();
    end
endmodule
